// ===== logic/pgp_top.sv
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module pgp_top #(
  parameter int unsigned DEBOUNCE_CYCLES   = pgp_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned POWER_DOWN_CYCLES = pgp_pkg::POWER_DOWN_CYCLES
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pgp_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [1:0]                  pin_in,
  output logic      [1:0]                  pin_out,
  output logic      [1:0]                  pin_oe,
  output logic      [1:0]                  pin_pull_up,
  output logic      [1:0]                  pin_pull_down,
  output logic      [1:0]                  pin_high_drive,
  output logic      [1:0]                  pin_ctrl_level,
  input  wire logic                        low_power_mode,
  input  wire logic                        power_cycle,
  input  wire logic                        ext_irq_pending,
  output logic                             irq
);

  localparam int PD_W = $clog2(POWER_DOWN_CYCLES + 1);
  localparam logic [PD_W-1:0] PD_LAST = PD_W'(POWER_DOWN_CYCLES - 1);
  localparam int NP = pgp_pkg::NUM_PINS;

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.
  pgp_pkg::pgp_setup_type        setup_q [NP];
  pgp_pkg::pgp_func_type         func_q  [NP];
  logic                          drive_q [NP];
  logic [pgp_pkg::EVT_W-1:0]     evt_status_q;
  logic [pgp_pkg::EVT_W-1:0]     evt_enable_q;
  logic [31:0]                   prdata_q;
  logic                          pslverr_q;
  logic [NP-1:0]                 level_prev_q;
  logic [NP-1:0]                 sense_prev_q;
  pgp_pkg::pgp_pad_type          pad_q   [NP];
  logic                          irq_q;
  logic [PD_W-1:0]               pd_cnt_q;
  logic                          pd_busy_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  function automatic logic mapped(input logic [7:0] idx);
    case (idx)
      pgp_pkg::IDX_PIN0_SETUP,  pgp_pkg::IDX_PIN1_SETUP,
      pgp_pkg::IDX_PIN0_FUNC,   pgp_pkg::IDX_PIN1_FUNC,
      pgp_pkg::IDX_PIN0_DRIVE,  pgp_pkg::IDX_PIN1_DRIVE,
      pgp_pkg::IDX_PIN_READBACK, pgp_pkg::IDX_EVENT_STATUS,
      pgp_pkg::IDX_EVENT_CLEAR, pgp_pkg::IDX_EVENT_ENABLE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  wire [7:0] reg_idx   = paddr[9:2];
  wire       addr_ok   = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) && mapped(reg_idx);
  wire       setup_ph  = psel && !penable;
  wire       wr_access = psel && penable && pwrite && pstrb[0] && addr_ok;
  wire [7:0] wbyte     = pwdata[7:0];

  wire wr_setup0 = wr_access && (reg_idx == pgp_pkg::IDX_PIN0_SETUP);
  wire wr_setup1 = wr_access && (reg_idx == pgp_pkg::IDX_PIN1_SETUP);
  wire wr_func0  = wr_access && (reg_idx == pgp_pkg::IDX_PIN0_FUNC);
  wire wr_func1  = wr_access && (reg_idx == pgp_pkg::IDX_PIN1_FUNC);
  wire wr_drive0 = wr_access && (reg_idx == pgp_pkg::IDX_PIN0_DRIVE);
  wire wr_drive1 = wr_access && (reg_idx == pgp_pkg::IDX_PIN1_DRIVE);
  wire wr_clear  = wr_access && (reg_idx == pgp_pkg::IDX_EVENT_CLEAR);
  wire wr_enable = wr_access && (reg_idx == pgp_pkg::IDX_EVENT_ENABLE);

  wire [1:0] wr_setup = {wr_setup1, wr_setup0};
  wire [1:0] wr_func  = {wr_func1, wr_func0};
  wire [1:0] wr_drive = {wr_drive1, wr_drive0};

  ////////////////////////////////////////////////////////////////////////////////
  // Input path and sensing.
  logic [NP-1:0] level_filt;
  logic [NP-1:0] sensing;
  logic [NP-1:0] general;
  logic [NP-1:0] readback;

  for (genvar n = 0; n < NP; n++) begin : g_pin_in
    pgp_pin_filter #(
      .DEB_CYCLES (DEBOUNCE_CYCLES)
    ) u_filter (
      .pclk        (pclk),
      .presetn     (presetn),
      .pin_raw     (pin_in[n]),
      .debounce_en (setup_q[n].debounce),
      .level       (level_filt[n])
    );
    assign general[n]  = func_q[n] == pgp_pkg::PGP_FUNC_GENERAL;
    assign sensing[n]  = general[n] && setup_q[n].input_enable && !low_power_mode;
    assign readback[n] = sensing[n] && level_filt[n];
  end

  // Regulators take this level; they obey it only when their own pin control is selected.
  assign pin_ctrl_level = readback;

  ////////////////////////////////////////////////////////////////////////////////
  // Edge events. Sensing is required in both cycles so that turning the input
  // buffer on never reads as an edge.
  logic [pgp_pkg::EVT_W-1:0] evt_set;

  for (genvar n = 0; n < NP; n++) begin : g_edge
    wire both_sense = sensing[n] && sense_prev_q[n];
    assign evt_set[2*n+pgp_pkg::EVT_RISE_OF] = both_sense && level_filt[n] && !level_prev_q[n]
                                               && evt_enable_q[2*n+pgp_pkg::EVT_RISE_OF];
    assign evt_set[2*n+pgp_pkg::EVT_FALL_OF] = both_sense && !level_filt[n] && level_prev_q[n]
                                               && evt_enable_q[2*n+pgp_pkg::EVT_FALL_OF];
  end

  // A new edge in the clearing cycle survives the clear.
  wire [pgp_pkg::EVT_W-1:0] evt_clr      = wr_clear ? wbyte[pgp_pkg::EVT_W-1:0] : '0;
  wire [pgp_pkg::EVT_W-1:0] evt_status_d = (evt_status_q & ~evt_clr) | evt_set;

  wire own_irq = |(evt_status_q & evt_enable_q);
  wire any_irq = own_irq || ext_irq_pending;

  ////////////////////////////////////////////////////////////////////////////////
  // Output path.
  pgp_pkg::pgp_pad_type pad_d [NP];

  always_comb begin
    for (int n = 0; n < NP; n++) begin
      logic want_lvl;
      logic drive_on;
      want_lvl = 1'b0;
      drive_on = 1'b0;
      case (func_q[n])
        pgp_pkg::PGP_FUNC_GENERAL: begin
          want_lvl = drive_q[n];
          drive_on = 1'b1;
        end
        pgp_pkg::PGP_FUNC_IRQ_OUT_ACTIVE_LOW: begin
          want_lvl = !any_irq;
          drive_on = 1'b1;
        end
        pgp_pkg::PGP_FUNC_IRQ_OUT_ACTIVE_HIGH: begin
          want_lvl = any_irq;
          drive_on = 1'b1;
        end
        default: begin
          want_lvl = 1'b0;
          drive_on = 1'b0;
        end
      endcase
      drive_on = drive_on && setup_q[n].output_enable && !low_power_mode;
      // Open-drain only ever sinks, which keeps the pin from feeding a dead host rail.
      pad_d[n].drv        = want_lvl && !setup_q[n].open_drain_enable;
      pad_d[n].oe         = drive_on && (!setup_q[n].open_drain_enable || !want_lvl);
      pad_d[n].pull_up    = setup_q[n].pull_up && !low_power_mode;
      pad_d[n].pull_down  = setup_q[n].pull_down && !low_power_mode;
      pad_d[n].high_drive = setup_q[n].high_drive;
    end
  end

  for (genvar n = 0; n < NP; n++) begin : g_pad_out
    assign pin_out[n]        = pad_q[n].drv;
    assign pin_oe[n]         = pad_q[n].oe;
    assign pin_pull_up[n]    = pad_q[n].pull_up;
    assign pin_pull_down[n]  = pad_q[n].pull_down;
    assign pin_high_drive[n] = pad_q[n].high_drive;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power cycle. The pins keep their setting until the delay has run out.
  wire pd_done = pd_busy_q && (pd_cnt_q == PD_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_busy_q <= 1'b0;
      pd_cnt_q  <= '0;
    end else if (pd_done) begin
      pd_busy_q <= 1'b0;
      pd_cnt_q  <= '0;
    end else if (pd_busy_q) begin
      pd_cnt_q <= pd_cnt_q + PD_W'(1);
    end else if (power_cycle) begin
      pd_busy_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux.
  logic [7:0] rd_byte;

  always_comb begin
    case (reg_idx)
      pgp_pkg::IDX_PIN0_SETUP:   rd_byte = {1'b0, setup_q[0][6:0]};
      pgp_pkg::IDX_PIN1_SETUP:   rd_byte = {1'b0, setup_q[1][6:0]};
      pgp_pkg::IDX_PIN0_FUNC:    rd_byte = {6'h00, func_q[0]};
      pgp_pkg::IDX_PIN1_FUNC:    rd_byte = {6'h00, func_q[1]};
      pgp_pkg::IDX_PIN0_DRIVE:   rd_byte = {7'h00, drive_q[0]};
      pgp_pkg::IDX_PIN1_DRIVE:   rd_byte = {7'h00, drive_q[1]};
      pgp_pkg::IDX_PIN_READBACK: rd_byte = {5'h00, 1'b0, readback};
      pgp_pkg::IDX_EVENT_STATUS: rd_byte = {4'h0, evt_status_q};
      pgp_pkg::IDX_EVENT_ENABLE: rd_byte = {4'h0, evt_enable_q};
      default:                   rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      prdata_q  <= (addr_ok && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr_q <= !addr_ok;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = pslverr_q && psel && penable;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-pin registers; each pin has its own storage and its own write strobe.
  for (genvar n = 0; n < NP; n++) begin : g_pin_regs
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        setup_q[n] <= pgp_pkg::SETUP_RESET;
        func_q[n]  <= pgp_pkg::PGP_FUNC_GENERAL;
        drive_q[n] <= pgp_pkg::DRIVE_RESET;
      end else if (pd_done) begin
        setup_q[n] <= pgp_pkg::SETUP_RESET;
        func_q[n]  <= pgp_pkg::PGP_FUNC_GENERAL;
        drive_q[n] <= pgp_pkg::DRIVE_RESET;
      end else begin
        if (wr_setup[n]) begin
          setup_q[n] <= pgp_pkg::pgp_setup_type'({1'b0, wbyte[6:0]});
        end
        if (wr_func[n]) begin
          func_q[n] <= pgp_pkg::pgp_func_type'(wbyte[1:0]);
        end
        if (wr_drive[n]) begin
          drive_q[n] <= wbyte[0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Events, pads and interrupt.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status_q <= pgp_pkg::EVENT_RESET;
      evt_enable_q <= pgp_pkg::EVENT_RESET;
    end else if (pd_done) begin
      evt_status_q <= pgp_pkg::EVENT_RESET;
      evt_enable_q <= pgp_pkg::EVENT_RESET;
    end else begin
      evt_status_q <= evt_status_d;
      if (wr_enable) begin
        evt_enable_q <= wbyte[pgp_pkg::EVT_W-1:0];
      end
    end
  end

  for (genvar n = 0; n < NP; n++) begin : g_pad_regs
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pad_q[n] <= '{drv: 1'b0, oe: 1'b0, pull_up: 1'b0, pull_down: 1'b1, high_drive: 1'b0};
      end else begin
        pad_q[n] <= pad_d[n];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_prev_q <= '0;
      sense_prev_q <= '0;
      irq_q        <= 1'b0;
    end else begin
      level_prev_q <= level_filt;
      sense_prev_q <= sensing;
      irq_q        <= own_irq && !low_power_mode;
    end
  end

  assign irq = irq_q;

endmodule // pgp_top

// ===== logic/pgp_pkg.sv
// Summary of operation
// - After reset each pin is an input with pull-down; setup reads 0x09.
// - Exactly two pins, each with its own setup, function and drive registers.
// - In hibernate or ship mode pins neither sense, drive nor signal interrupts.
// - General purpose pin with input buffer on reports its level in readback.
// - Rising or falling edge sets an event flag when that edge is enabled.
// - Regulators follow a configured general purpose pin only with their pin control.
// - General purpose pin with output buffer on drives its drive-value bit.
// - A power cycle returns both pins to defaults after the power-down delay.
// - Function 1 gives an active-low, 2 an active-high interrupt output.
// - Interrupt output pin asserts while any enabled event of any source is pending; the irq port counts only the pins' own events.
// - Debounce bit adds a 10 ms filter; drive bit picks weak or strong drive.
// - Setup bits: input 0, output 1, open-drain 2, pulls 3 and 4, drive 5, debounce 6.
// - Function select is bits 1:0, reset 0; value 0 means general purpose.
// - Drive-value bit 0 sets pin low or high; reset value is 0.
// - Readback bit 0 is pin zero, bit 1 pin one; bit 2 reserved.
package pgp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int NUM_PINS = 2;
  localparam int ADDR_W   = 12;

  // Register indexes; byte address is four times the index.
  localparam logic [7:0] IDX_PIN0_SETUP    = 8'h80;
  localparam logic [7:0] IDX_PIN1_SETUP    = 8'h81;
  localparam logic [7:0] IDX_PIN0_FUNC     = 8'h83;
  localparam logic [7:0] IDX_PIN1_FUNC     = 8'h84;
  localparam logic [7:0] IDX_PIN0_DRIVE    = 8'h86;
  localparam logic [7:0] IDX_PIN1_DRIVE    = 8'h87;
  localparam logic [7:0] IDX_PIN_READBACK  = 8'h89;
  localparam logic [7:0] IDX_EVENT_STATUS  = 8'ha0;
  localparam logic [7:0] IDX_EVENT_CLEAR   = 8'ha1;
  localparam logic [7:0] IDX_EVENT_ENABLE  = 8'ha2;

  localparam logic [7:0] SETUP_RESET = 8'h09;
  localparam logic [1:0] FUNC_RESET  = 2'h0;
  localparam logic       DRIVE_RESET = 1'b0;
  localparam logic [3:0] EVENT_RESET = 4'h0;

  // Event layout: bit 2n rising edge of pin n, bit 2n+1 falling edge of pin n.
  localparam int EVT_W       = 4;
  localparam int EVT_RISE_OF = 0;
  localparam int EVT_FALL_OF = 1;

  localparam int CLK_MHZ              = 250;
  localparam int DEBOUNCE_MS          = 10;
  localparam int DEBOUNCE_CYCLES      = DEBOUNCE_MS * CLK_MHZ * 1000;
  localparam int POWER_DOWN_DELAY_US  = 100;
  localparam int POWER_DOWN_CYCLES    = POWER_DOWN_DELAY_US * CLK_MHZ;

  typedef enum logic [1:0] {
    PGP_FUNC_GENERAL             = 2'h0,
    PGP_FUNC_IRQ_OUT_ACTIVE_LOW  = 2'h1,
    PGP_FUNC_IRQ_OUT_ACTIVE_HIGH = 2'h2,
    PGP_FUNC_NONE                = 2'h3
  } pgp_func_type;

  typedef struct packed {
    logic reserved;
    logic debounce;
    logic high_drive;
    logic pull_up;
    logic pull_down;
    logic open_drain_enable;
    logic output_enable;
    logic input_enable;
  } pgp_setup_type;

  typedef struct packed {
    logic drv;
    logic oe;
    logic pull_up;
    logic pull_down;
    logic high_drive;
  } pgp_pad_type;

endpackage

// ===== logic/pgp_pin_filter.sv
`timescale 1ns/1ps
module pgp_pin_filter #(
  parameter int unsigned DEB_CYCLES = 2500000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_raw,
  input  wire logic debounce_en,
  output logic      level
);

  localparam int CNT_W = $clog2(DEB_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEB_CYCLES - 1);

  logic             sync1_q;
  logic             sync2_q;
  logic             level_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             level_d;
  wire              differs = sync2_q != level_q;

  ////////////////////////////////////////////////////////////////////////////////
  // The counter restarts on every bounce, so only a level stable for the whole
  // filter time is passed on; this costs the full filter time of latency.
  always_comb begin
    cnt_d   = '0;
    level_d = level_q;
    if (!debounce_en) begin
      level_d = sync2_q;
    end else if (differs) begin
      if (cnt_q == CNT_LAST) begin
        level_d = sync2_q;
      end else begin
        cnt_d = cnt_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      level_q <= 1'b0;
      cnt_q   <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      level_q <= level_d;
      cnt_q   <= cnt_d;
    end
  end

  assign level = level_q;

endmodule // pgp_pin_filter

// ===== dv/pgp_top_chk.sv
`timescale 1ns/1ps
module pgp_top_chk #(
  parameter int unsigned DEBOUNCE_CYCLES   = 8,
  parameter int unsigned POWER_DOWN_CYCLES = 6
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  pin_in,
  input wire logic [1:0]  pin_out,
  input wire logic [1:0]  pin_oe,
  input wire logic [1:0]  pin_pull_up,
  input wire logic [1:0]  pin_pull_down,
  input wire logic [1:0]  pin_high_drive,
  input wire logic [1:0]  pin_ctrl_level,
  input wire logic        low_power_mode,
  input wire logic        power_cycle,
  input wire logic        ext_irq_pending,
  input wire logic        irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic bus_wr;
  assign bus_wr = psel && penable && pwrite && pstrb[0];
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_lp_held;
    low_power_mode [*3];
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_ready_always: assert property (pready) else $error("pready low");
  a_err_in_access: assert property (pslverr |-> s_access) else $error("pslverr outside access");
  a_read_narrow: assert property (s_access ##0 !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data above bit 7 set");
  a_lp_pads_off: assert property (s_lp_held |-> pin_oe == 2'b00 && pin_pull_down == 2'b00)
    else $error("pads active in low power");
  a_lp_no_irq: assert property (s_lp_held |-> !irq) else $error("irq in low power");
  a_lp_no_sense: assert property (low_power_mode |-> pin_ctrl_level == 2'b00)
    else $error("pin level sensed in low power");
  a_level_from_pin: assert property ($rose(pin_ctrl_level[0]) |-> $past(pin_in[0], 3))
    else $error("pin level rose without pin high");
  // Pull-up and high-drive only move after a register write, a power cycle or a low power change; this check leaves out the power cycle.
  a_pad_cause: assert property ($changed({pin_pull_up, pin_high_drive}) |->
    $past(bus_wr) || $past(bus_wr, 2) || ($past(low_power_mode) != $past(low_power_mode, 3)))
    else $error("pad control changed without cause");
endmodule // pgp_top_chk

// ===== dv/pgp_pin_host.sv
`timescale 1ns/1ps
module pgp_pin_host (
  input  wire logic       pclk,
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe,
  input  wire logic [1:0] pin_pull_up,
  input  wire logic [1:0] pin_pull_down,
  input  wire logic [1:0] host_en,
  input  wire logic [1:0] host_level,
  output logic      [1:0] pin_in
);
  logic [1:0] float_q = 2'b01;
  ////////////////////////////////////////////////////////////////////////////////
  // A released line with no pull wanders, so it shows a pattern that changes every cycle.
  always @(posedge pclk) begin
    float_q <= ~float_q;
  end
  // The host drives only a line that the device has let go of, so they never fight.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : host_en[i] ? host_level[i] :
                  pin_pull_up[i] ? 1'b1 : pin_pull_down[i] ? 1'b0 : float_q[i];
    end
  end
endmodule // pgp_pin_host

// ===== dv/pgp_top_test.sv
`timescale 1ns/1ps
module pgp_top_test;
  localparam int unsigned DEB = 8;
  localparam int unsigned PDC = 6;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, low_power_mode, power_cycle;
  logic        ext_irq_pending, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [3:0]  pstrb;
  logic [1:0]  pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down, pin_high_drive;
  logic [1:0]  pin_ctrl_level, host_en, host_level;
  int          seed = 32'h28cc74c0;
  int          miscompares = 0;
  int          checked = 0;
  logic [32:0] exp_q[$];
  pgp_top #(.DEBOUNCE_CYCLES(DEB), .POWER_DOWN_CYCLES(PDC)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .pin_in, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down, .pin_high_drive,
    .pin_ctrl_level, .low_power_mode, .power_cycle, .ext_irq_pending, .irq);
  pgp_pin_host host_u (
    .pclk, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down, .host_en, .host_level, .pin_in);
  always #2 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Every transfer ends with one idle edge so the strobes are never set twice in a step.
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
                      input logic [32:0] e);
    int n;
    exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] r;
    r = $random(seed);
    xfer(1'b1, idx, {r[31:8], v}, 33'h0);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] v);
    xfer(1'b0, idx, 32'h0, {25'h0, v});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      chk("apb", exp_q.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
    end
  end
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, low_power_mode, power_cycle, ext_irq_pending} = 6'h0;
    {paddr, pwdata, pstrb, host_en, host_level} = {12'h0, 32'h0, 4'hf, 4'h0};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(pgp_pkg::IDX_PIN0_SETUP, 8'h09);
    rd(pgp_pkg::IDX_PIN1_SETUP, 8'h09);
    rd(pgp_pkg::IDX_PIN0_FUNC, 8'h00);
    rd(pgp_pkg::IDX_PIN1_FUNC, 8'h00);
    rd(pgp_pkg::IDX_PIN0_DRIVE, 8'h00);
    rd(pgp_pkg::IDX_PIN1_DRIVE, 8'h00);
    chk("pull_down", 33'(2'b11), 33'(pin_pull_down));
    chk("oe", 33'(2'b00), 33'(pin_oe));
    xfer(1'b0, 8'h82, 32'h0, {1'b1, 32'h0});
    pstrb <= 4'he;
    wr(pgp_pkg::IDX_PIN1_SETUP, 8'h00);
    pstrb <= 4'hf;
    rd(pgp_pkg::IDX_PIN1_SETUP, 8'h09);
    wr(pgp_pkg::IDX_PIN_READBACK, 8'hff);
    rd(pgp_pkg::IDX_PIN_READBACK, 8'h00);
    host_en <= 2'b11;
    for (int i = 0; i < 4; i++) begin
      rnd = $random(seed);
      host_level <= rnd[1:0];
      cyc(6);
      rd(pgp_pkg::IDX_PIN_READBACK, {6'h0, rnd[1:0]});
      chk("ctrl_level", 33'(rnd[1:0]), 33'(pin_ctrl_level));
    end
    host_level <= 2'b00;
    cyc(6);
    wr(pgp_pkg::IDX_EVENT_CLEAR, 8'h0f);
    wr(pgp_pkg::IDX_EVENT_ENABLE, 8'h06);
    host_level <= 2'b11;
    cyc(8);
    rd(pgp_pkg::IDX_EVENT_STATUS, 8'h04);
    chk("irq", 33'h1, 33'(irq));
    host_level <= 2'b00;
    cyc(8);
    rd(pgp_pkg::IDX_EVENT_STATUS, 8'h06);
    wr(pgp_pkg::IDX_EVENT_CLEAR, 8'h0f);
    cyc(3);
    chk("irq", 33'h0, 33'(irq));
    wr(pgp_pkg::IDX_EVENT_ENABLE, 8'h00);
    host_level <= 2'b11;
    cyc(8);
    rd(pgp_pkg::IDX_EVENT_STATUS, 8'h00);
    host_en <= 2'b00;
    wr(pgp_pkg::IDX_PIN0_SETUP, 8'h23);
    rd(pgp_pkg::IDX_PIN0_SETUP, 8'h23);
    wr(pgp_pkg::IDX_PIN0_DRIVE, 8'h01);
    cyc(2);
    chk("oe", 33'(2'b01), 33'(pin_oe));
    chk("out0", 33'h1, 33'(pin_out[0]));
    chk("high_drive", 33'(2'b01), 33'(pin_high_drive));
    cyc(4);
    rd(pgp_pkg::IDX_PIN_READBACK, 8'h01);
    wr(pgp_pkg::IDX_PIN0_SETUP, 8'h07);
    cyc(2);
    chk("oe", 33'(2'b00), 33'(pin_oe));
    wr(pgp_pkg::IDX_PIN0_DRIVE, 8'h00);
    cyc(2);
    chk("oe", 33'(2'b01), 33'(pin_oe));
    wr(pgp_pkg::IDX_PIN1_SETUP, 8'h13);
    cyc(2);
    chk("pull_up", 33'(2'b10), 33'(pin_pull_up));
    for (int f = 1; f < 3; f++) begin
      for (int e = 0; e < 2; e++) begin
        wr(pgp_pkg::IDX_PIN1_FUNC, 8'(f));
        ext_irq_pending <= e[0];
        cyc(3);
        chk("irq_pin", {32'h0, (f == 2) ^ (e == 0)}, 33'(pin_out[1]));
      end
    end
    ext_irq_pending <= 1'b0;
    wr(pgp_pkg::IDX_PIN1_FUNC, 8'h00);
    wr(pgp_pkg::IDX_PIN1_SETUP, 8'h09);
    wr(pgp_pkg::IDX_PIN0_SETUP, 8'h49);
    host_en <= 2'b11;
    host_level <= 2'b00;
    cyc(DEB + 6);
    host_level <= 2'b01;
    cyc(3);
    host_level <= 2'b00;
    cyc(DEB + 6);
    chk("debounce", 33'h0, 33'(pin_ctrl_level[0]));
    wr(pgp_pkg::IDX_EVENT_ENABLE, 8'h04);
    host_level <= 2'b11;
    cyc(DEB + 6);
    chk("debounce", 33'(2'b11), 33'(pin_ctrl_level));
    chk("irq", 33'h1, 33'(irq));
    low_power_mode <= 1'b1;
    cyc(4);
    chk("lp_pads", 33'h0, 33'({pin_oe, pin_pull_down, pin_ctrl_level, irq}));
    rd(pgp_pkg::IDX_PIN_READBACK, 8'h00);
    low_power_mode <= 1'b0;
    cyc(4);
    chk("irq", 33'h1, 33'(irq));
    wr(pgp_pkg::IDX_PIN0_SETUP, 8'h03);
    power_cycle <= 1'b1;
    @(posedge pclk);
    power_cycle <= 1'b0;
    rd(pgp_pkg::IDX_PIN0_SETUP, 8'h03);
    cyc(PDC + 4);
    rd(pgp_pkg::IDX_PIN0_SETUP, 8'h09);
    rd(pgp_pkg::IDX_EVENT_ENABLE, 8'h00);
    chk("pull_down", 33'(2'b11), 33'(pin_pull_down));
    final_report();
  end
endmodule // pgp_top_test
bind pgp_top pgp_top_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
  .POWER_DOWN_CYCLES(POWER_DOWN_CYCLES)) chk_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .pin_in, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down, .pin_high_drive,
  .pin_ctrl_level, .low_power_mode, .power_cycle, .ext_irq_pending, .irq);
